// ---- hdl/pafo_pkg.sv ----
// constants, pin map and test controller states for the pin override block
// Functional notes
// - test port enabled: test pins pulled up, direction fixed, no input except on the clock pin
// - tester presents data on test-data-in; device shifts it into IR or DR
// - test-data-out driven only in shift states, else weakly pulled high
// - tester drives mode-select; device samples it for next state
// - test-port activity is timed by the test clock pin, not system clock
// - second port bit 5 input only, pull-up on; fuse programmed: not reset
// - second port bits 4 and 3 feed timer 0 and timer 1, no overrides
// - lower four analog pins of first port keep normal port control
// - third port pins are pin-change sources 16 to 23 in pin order
// - third port input-enable override is mask and group enable, value 0
// - fourth port pins 0 to 6 are pin-change sources 24 to 30
package pafo_pkg;
   localparam int PIN_COUNT = 32;
   // pin index = group base + bit
   localparam int GRP_F = 0;
   localparam int GRP_G = 8;
   localparam int GRP_H = 16;
   localparam int GRP_J = 24;
   localparam int GRP_W = 8;
   localparam int J_SRC_W = 7;
   localparam int TP_TDI = GRP_F + 7;
   localparam int TP_TDO = GRP_F + 6;
   localparam int TP_TMS = GRP_F + 5;
   localparam int TP_TCK = GRP_F + 4;
   localparam int ANA_LOW_W = 4;
   localparam int G_RST = GRP_G + 5;
   localparam int G_T0 = GRP_G + 4;
   localparam int G_T1 = GRP_G + 3;
   localparam logic FUSE_PROGRAMMED = 1'b0;
   localparam logic [3:0] TP_PINS_ALL = 4'hf;
   // test controller registers
   localparam int IR_W = 4;
   localparam int SCAN_W = 8;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
   localparam logic [IR_W-1:0] IR_RESET = 4'hf;
   localparam logic [SCAN_W-1:0] SCAN_RESET = 8'h00;
   typedef enum logic [3:0] {
      TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2,
      TAP_CAP_DR = 4'h3, TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5,
      TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7, TAP_UPD_DR = 4'h8,
      TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
      TAP_EX1_IR = 4'hc, TAP_PAU_IR = 4'hd, TAP_EX2_IR = 4'he,
      TAP_UPD_IR = 4'hf
   } pafo_tap_t;
endpackage

// ---- hdl/pafo_top.sv ----
// alternate-function override and test access controller for four pin groups
`timescale 1ns/1ps
module pafo_top (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic test_port_enabled_in,
   input wire logic reset_pin_disable_fuse_in,
   input wire logic pin_change_group_enable_in,
   input wire logic [pafo_pkg::GRP_W-1:0] pin_change_mask_h_in,
   input wire logic [pafo_pkg::J_SRC_W-1:0] pin_change_mask_j_in,
   input wire logic [pafo_pkg::PIN_COUNT-1:0] reg_pullup_in,
   input wire logic [pafo_pkg::PIN_COUNT-1:0] reg_dir_in,
   input wire logic [pafo_pkg::PIN_COUNT-1:0] reg_out_in,
   input wire logic [pafo_pkg::PIN_COUNT-1:0] reg_die_in,
   input wire logic [pafo_pkg::PIN_COUNT-1:0] pin_level_in,
   output logic [pafo_pkg::PIN_COUNT-1:0] pin_pullup_out,
   output logic [pafo_pkg::PIN_COUNT-1:0] pin_oe_out,
   output logic [pafo_pkg::PIN_COUNT-1:0] pin_drive_out,
   output logic [pafo_pkg::PIN_COUNT-1:0] pin_die_out,
   output logic [pafo_pkg::PIN_COUNT-1:0] pin_din_out,
   output logic reset_request_out,
   output logic timer0_count_input_out,
   output logic timer1_count_input_out,
   output logic [pafo_pkg::GRP_W-1:0] pin_change_source_h_out,
   output logic [pafo_pkg::J_SRC_W-1:0] pin_change_source_j_out,
   output logic [pafo_pkg::IR_W-1:0] instruction_out,
   output logic [pafo_pkg::SCAN_W-1:0] scan_data_out
);
   import pafo_pkg::*;

   logic [PIN_COUNT-1:0] sync1_ff;
   logic [PIN_COUNT-1:0] sync2_ff;
   logic tck_prev_ff;
   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;
   pafo_tap_t tap_state_ff;
   pafo_tap_t nxt_tap_state;
   logic [IR_W-1:0] ir_shift_ff;
   logic [IR_W-1:0] ir_ff;
   logic [SCAN_W-1:0] scan_shift_ff;
   logic bypass_ff;
   logic tdo_ff;
   logic shifting;
   logic [PIN_COUNT-1:0] pu_oe;
   logic [PIN_COUNT-1:0] pu_ov;
   logic [PIN_COUNT-1:0] dd_oe;
   logic [PIN_COUNT-1:0] dd_ov;
   logic [PIN_COUNT-1:0] pv_oe;
   logic [PIN_COUNT-1:0] pv_ov;
   logic [PIN_COUNT-1:0] die_oe;
   logic [PIN_COUNT-1:0] die_ov;

   ////////////////////////////////////////////////////////////////////////
   // pins arrive from outside: two flops before anything looks at them
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= pin_level_in;
         sync2_ff <= sync1_ff;
      end
   end

   // test clock edges become one-cycle enables, so it must run well below
   // a quarter of the system clock
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tck_prev_ff <= 1'b0;
      end else begin
         tck_prev_ff <= sync2_ff[TP_TCK];
      end
   end

   assign tck_rise = sync2_ff[TP_TCK] & ~tck_prev_ff;
   assign tck_fall = ~sync2_ff[TP_TCK] & tck_prev_ff;
   assign tms_s = sync2_ff[TP_TMS];
   assign tdi_s = sync2_ff[TP_TDI];
   assign shifting = (tap_state_ff == TAP_SH_IR) ||
                     (tap_state_ff == TAP_SH_DR);

   ////////////////////////////////////////////////////////////////////////
   // controller next state from the sampled mode-select level
   always_comb begin
      nxt_tap_state = tap_state_ff;
      unique case (tap_state_ff)
         TAP_RESET:  nxt_tap_state = tms_s ? TAP_RESET : TAP_IDLE;
         TAP_IDLE:   nxt_tap_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: nxt_tap_state = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: nxt_tap_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  nxt_tap_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: nxt_tap_state = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: nxt_tap_state = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: nxt_tap_state = tms_s ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: nxt_tap_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: nxt_tap_state = tms_s ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: nxt_tap_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  nxt_tap_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: nxt_tap_state = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: nxt_tap_state = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: nxt_tap_state = tms_s ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: nxt_tap_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   // controller held in reset while the port is disabled
   always_ff @(posedge clk_in) begin
      if (reset_in || !test_port_enabled_in) begin
         tap_state_ff <= TAP_RESET;
      end else if (tck_rise) begin
         tap_state_ff <= nxt_tap_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction path: capture, shift on rising edge, update on falling
   always_ff @(posedge clk_in) begin
      if (reset_in || !test_port_enabled_in) begin
         ir_shift_ff <= IR_RESET;
         ir_ff <= IR_RESET;
      end else begin
         if (tck_rise && tap_state_ff == TAP_CAP_IR) begin
            ir_shift_ff <= IR_CAPTURE;
         end else if (tck_rise && tap_state_ff == TAP_SH_IR) begin
            ir_shift_ff <= {tdi_s, ir_shift_ff[IR_W-1:1]};
         end
         if (tck_fall && tap_state_ff == TAP_UPD_IR) begin
            ir_ff <= ir_shift_ff;
         end
      end
   end

   // data path: bypass bit for the bypass code, scan chain otherwise
   always_ff @(posedge clk_in) begin
      if (reset_in || !test_port_enabled_in) begin
         bypass_ff <= 1'b0;
         scan_shift_ff <= SCAN_RESET;
      end else if (tck_rise) begin
         if (tap_state_ff == TAP_CAP_DR) begin
            bypass_ff <= 1'b0;
            scan_shift_ff <= scan_data_out;
         end else if (tap_state_ff == TAP_SH_DR) begin
            if (ir_ff == IR_BYPASS) begin
               bypass_ff <= tdi_s;
            end else begin
               scan_shift_ff <= {tdi_s, scan_shift_ff[SCAN_W-1:1]};
            end
         end
      end
   end

   // scan result and instruction seen by the rest of the chip
   always_ff @(posedge clk_in) begin
      if (reset_in || !test_port_enabled_in) begin
         scan_data_out <= SCAN_RESET;
         instruction_out <= IR_RESET;
      end else begin
         instruction_out <= ir_ff;
         if (tck_fall && tap_state_ff == TAP_UPD_DR &&
             ir_ff != IR_BYPASS) begin
            scan_data_out <= scan_shift_ff;
         end
      end
   end

   // serial output changes on the falling edge so the tester samples it
   // stably on the next rising edge
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tdo_ff <= 1'b1;
      end else if (tck_fall && shifting) begin
         if (tap_state_ff == TAP_SH_IR) begin
            tdo_ff <= ir_shift_ff[0];
         end else if (ir_ff == IR_BYPASS) begin
            tdo_ff <= bypass_ff;
         end else begin
            tdo_ff <= scan_shift_ff[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // override enables and values for every pin
   always_comb begin
      pu_oe = '0;
      pu_ov = '0;
      dd_oe = '0;
      dd_ov = '0;
      pv_oe = '0;
      pv_ov = '0;
      die_oe = '0;
      die_ov = '0;
      // test pins; lower analog pins and timer pins keep all zeros
      pu_oe[TP_TCK +: 4] = {4{test_port_enabled_in}};
      pu_ov[TP_TCK +: 4] = TP_PINS_ALL;
      dd_oe[TP_TCK +: 4] = {4{test_port_enabled_in}};
      die_oe[TP_TCK +: 4] = {4{test_port_enabled_in}};
      die_ov[TP_TCK] = 1'b1; // clock pin keeps its input
      dd_ov[TP_TDO] = shifting;
      pv_oe[TP_TDO] = test_port_enabled_in;
      pv_ov[TP_TDO] = tdo_ff;
      // reset pin: input only, pull-up always on
      pu_oe[G_RST] = 1'b1;
      pu_ov[G_RST] = 1'b1;
      dd_oe[G_RST] = 1'b1;
      pv_oe[G_RST] = 1'b1;
      // pin-change groups disable their digital input when armed
      die_oe[GRP_H +: GRP_W] =
         pin_change_mask_h_in & {GRP_W{pin_change_group_enable_in}};
      die_oe[GRP_J +: J_SRC_W] =
         pin_change_mask_j_in & {J_SRC_W{pin_change_group_enable_in}};
   end

   // one override mux per pin and per control, all registered
   generate
      for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
         always_ff @(posedge clk_in) begin
            if (reset_in) begin
               pin_pullup_out[i] <= 1'b0;
               pin_oe_out[i] <= 1'b0;
               pin_drive_out[i] <= 1'b0;
               pin_die_out[i] <= 1'b0;
               pin_din_out[i] <= 1'b0;
            end else begin
               pin_pullup_out[i] <=
                  pu_oe[i] ? pu_ov[i] : reg_pullup_in[i];
               pin_oe_out[i] <=
                  dd_oe[i] ? dd_ov[i] : reg_dir_in[i];
               pin_drive_out[i] <=
                  pv_oe[i] ? pv_ov[i] : reg_out_in[i];
               pin_die_out[i] <=
                  die_oe[i] ? die_ov[i] : reg_die_in[i];
               pin_din_out[i] <= sync2_ff[i] &
                                 (die_oe[i] ? die_ov[i] : reg_die_in[i]);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // alternate inputs routed to reset, timers and pin-change detector
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         reset_request_out <= 1'b0;
         timer0_count_input_out <= 1'b0;
         timer1_count_input_out <= 1'b0;
         pin_change_source_h_out <= '0;
         pin_change_source_j_out <= '0;
      end else begin
         // reset pin is active low; a programmed fuse makes it plain input
         reset_request_out <= (reset_pin_disable_fuse_in != FUSE_PROGRAMMED)
                              && !sync2_ff[G_RST];
         timer0_count_input_out <= sync2_ff[G_T0];
         timer1_count_input_out <= sync2_ff[G_T1];
         pin_change_source_h_out <= sync2_ff[GRP_H +: GRP_W];
         pin_change_source_j_out <= sync2_ff[GRP_J +: J_SRC_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   chk_test_pins_forced: assert property (
      test_port_enabled_in |=> (pin_pullup_out[TP_TCK +: 4] == TP_PINS_ALL)
         && (pin_die_out[TP_TDI] == 1'b0) && !pin_oe_out[TP_TMS])
      else $error("test pins not taken over");
   chk_tdo_idle_pulled: assert property (
      (test_port_enabled_in && !shifting) |=>
         !pin_oe_out[TP_TDO] && pin_pullup_out[TP_TDO])
      else $error("test data out driven outside shift");
   chk_tdo_shift_drive: assert property (
      (test_port_enabled_in && shifting) |=> pin_oe_out[TP_TDO])
      else $error("test data out not driven in shift");
   chk_tap_mode_select: assert property (
      (test_port_enabled_in && tck_rise && tap_state_ff == TAP_IDLE && tms_s
       && $past(test_port_enabled_in)) |=> tap_state_ff == TAP_SEL_DR)
      else $error("controller ignored mode select");
   chk_tap_waits_tck: assert property (
      (test_port_enabled_in && !tck_rise) |=> $stable(tap_state_ff))
      else $error("controller moved without test clock");
   chk_ir_shift_in: assert property (
      (test_port_enabled_in && tck_rise && tap_state_ff == TAP_SH_IR) |=>
         ir_shift_ff[IR_W-1] == $past(tdi_s))
      else $error("serial data not shifted into instruction");
   chk_reset_pin_fuse: assert property (
      (reset_pin_disable_fuse_in == FUSE_PROGRAMMED) |=>
         !reset_request_out && pin_pullup_out[G_RST] && !pin_oe_out[G_RST])
      else $error("reset pin not plain input");
   chk_timer_route: assert property (
      1'b1 |=> timer0_count_input_out == $past(sync2_ff[G_T0]) &&
         pin_pullup_out[G_T1] == $past(reg_pullup_in[G_T1]))
      else $error("timer pin routed or overridden wrongly");
   chk_analog_untouched: assert property (
      1'b1 |=> pin_oe_out[ANA_LOW_W-1:0] == $past(reg_dir_in[ANA_LOW_W-1:0])
         && pin_die_out[ANA_LOW_W-1:0] == $past(reg_die_in[ANA_LOW_W-1:0]))
      else $error("lower analog pins overridden");
   chk_pcint_die_off: assert property (
      (pin_change_group_enable_in && pin_change_mask_h_in[0]) |=>
         !pin_die_out[GRP_H])
      else $error("pin-change input enable override wrong");
   chk_pcint_route: assert property (
      ##1 pin_change_source_h_out == $past(sync2_ff[GRP_H +: GRP_W]) ##0
         pin_change_source_j_out == $past(sync2_ff[GRP_J +: J_SRC_W]))
      else $error("pin-change sources misrouted");

   cov_ir_shift: cover property (tap_state_ff == TAP_SH_IR && tck_rise);
   cov_dr_update: cover property (tap_state_ff == TAP_UPD_DR && tck_fall);
   cov_reset_request: cover property (reset_request_out);
   cov_pcint_armed: cover property (pin_change_group_enable_in &&
                                    |pin_change_mask_j_in);
endmodule

// ---- test/pafo_tester.sv ----
// tester model that drives the serial test pins from outside the device
`timescale 1ns/1ps
module pafo_tester #(
   parameter int HALF = 8
) (
   input wire logic clk_in,
   input wire logic tdo_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out
);
   ////////////////////////////////////////////////////////////////////////
   // clock stands low between frames; mode and data idle at pulled-up level
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
   end
   // one test clock period, slow against the system clock so the synchroniser
   // and edge detector inside always see both phases
   task automatic tick(input logic tms_v, input logic tdi_v,
                       output logic tdo_v);
      @(negedge clk_in);
      tms_out = tms_v;
      tdi_out = tdi_v;
      repeat (HALF) @(negedge clk_in);
      tdo_v = tdo_in; // sampled just before the rise
      tck_out = 1'b1;
      repeat (HALF) @(negedge clk_in);
      tck_out = 1'b0;
   endtask
   // steer the controller with n mode bits, first bit in path[0]
   task automatic walk(input logic [7:0] path, input int n);
      logic d;
      for (int i = 0; i < n; i++) begin
         tick(path[i], 1'b1, d);
      end
   endtask
   // shift n bits lsb first; mode goes high on the last bit to leave shift
   task automatic shift(input int n, input logic [7:0] din,
                        output logic [7:0] dout);
      dout = 8'h00;
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], dout[i]);
      end
   endtask
endmodule

// ---- test/tb.sv ----
// self-checking testbench for the pin override and test access block
`timescale 1ns/1ps
module tb;
   import pafo_pkg::*;
   logic clk_in, reset_in, tpe, fuse, gen;
   logic [7:0] mask_h, d;
   logic [6:0] mask_j;
   logic [31:0] rpu, rdir, rout, rdie, ext, level;
   logic [31:0] pin_pu, pin_oe, pin_drive, pin_die, pin_din;
   logic rst_req, t0, t1, tck, tms, tdi, tdo_line;
   logic [7:0] src_h, scan, prev;
   logic [6:0] src_j;
   logic [3:0] instr;
   int errors = 0;
   int checked = 0;
   // bit 13 is the reset pin, whose drive and input enable are left open
   localparam logic [31:0] M = 32'hffff_dfff;
   ////////////////////////////////////////////////////////////////////////
   // released test-data-out line floats up to its pull-up
   assign tdo_line = pin_oe[6] ? pin_drive[6] : 1'b1;
   assign level = {ext[31:8], tdi, tdo_line, tms, tck, ext[3:0]};
   pafo_top uut (.clk_in(clk_in), .reset_in(reset_in),
      .test_port_enabled_in(tpe), .reset_pin_disable_fuse_in(fuse),
      .pin_change_group_enable_in(gen), .pin_change_mask_h_in(mask_h),
      .pin_change_mask_j_in(mask_j), .reg_pullup_in(rpu), .reg_dir_in(rdir),
      .reg_out_in(rout), .reg_die_in(rdie), .pin_level_in(level),
      .pin_pullup_out(pin_pu), .pin_oe_out(pin_oe),
      .pin_drive_out(pin_drive), .pin_die_out(pin_die),
      .pin_din_out(pin_din), .reset_request_out(rst_req),
      .timer0_count_input_out(t0), .timer1_count_input_out(t1),
      .pin_change_source_h_out(src_h), .pin_change_source_j_out(src_j),
      .instruction_out(instr), .scan_data_out(scan));
   pafo_tester #(.HALF(8)) tester (.clk_in(clk_in), .tdo_in(tdo_line),
      .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
   ////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict, shared by the main sequence and the watchdog
   task automatic end_of_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // expected pin controls: 0 pull-up, 1 direction, 2 input enable, 3 drive
   function automatic logic [31:0] exp_vec(input int k);
      logic [31:0] v;
      case (k)
         0: begin
            v = rpu;
            if (tpe) v[7:4] = 4'hf;
            v[13] = 1'b1;
         end
         1: begin
            v = rdir;
            if (tpe) v[7:4] = 4'h0; // outside shift states
            v[13] = 1'b0;
         end
         2: begin
            v = rdie;
            if (tpe) v[7:4] = 4'h1;
            if (gen) begin
               v[23:16] = v[23:16] & ~mask_h;
               v[30:24] = v[30:24] & ~mask_j;
            end
         end
         default: begin
            v = rout;
            if (tpe) v[6] = 1'b1; // idle test-data-out value
         end
      endcase
      return v;
   endfunction
   // let the synchronised paths settle, then compare every pin
   task automatic check_pins();
      repeat (4) @(negedge clk_in);
      check_val(pin_pu, exp_vec(0));
      check_val(pin_oe, exp_vec(1));
      check_val(pin_die & M, exp_vec(2) & M);
      check_val(pin_drive & M, exp_vec(3) & M);
      check_val(pin_din & M, level & exp_vec(2) & M);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // 40 MHz system clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      errors++;
      $display("watchdog expired");
      end_of_test();
   end
   // main sequence, inputs change on the falling edge
   initial begin
      reset_in = 1'b1;
      {tpe, fuse, gen, mask_h, mask_j} = '0;
      rpu = 32'h5a5a_c3c3;
      rdir = 32'h0ff0_33cc;
      rout = 32'ha5a5_0f0f;
      rdie = 32'hffff_ffff;
      ext = 32'h1234_5678;
      repeat (4) @(negedge clk_in);
      check_val(pin_pu, 32'h0);
      check_val(instr, IR_RESET);
      reset_in = 1'b0;
      // plain port control, every bit both ways, analog pins untouched
      check_pins();
      {rpu, rdir, rout, rdie, ext} = ~{rpu, rdir, rout, rdie, ext};
      check_pins();
      $display("test 1 done");
      // test port takes its four pins
      tpe = 1'b1;
      check_pins();
      $display("test 2 done");
      // pin-change routing, timers and the reset pin with both fuse states
      gen = 1'b1;
      mask_h = 8'h96;
      mask_j = 7'h2b;
      // inputs enabled again so the pin-change override has bits to clear
      rdie = 32'hffff_ffff;
      for (int i = 0; i < 4; i++) begin
         ext = (i < 2) ? 32'h8e5a_1000 : 32'h71a5_e800;
         fuse = i[0];
         gen = (i != 3);
         check_pins();
         check_val(src_h, ext[23:16]);
         check_val(src_j, ext[30:24]);
         check_val(t0, ext[G_T0]);
         check_val(t1, ext[G_T1]);
         check_val(rst_req, fuse & ~ext[G_RST]);
      end
      $display("test 3 done");
      // instruction load: idle, select-dr, select-ir, capture, shift
      tester.walk(8'h06, 5);
      check_val(pin_oe[6], 1'b1);
      tester.shift(4, 8'h03, d);
      check_val(d[3:0], IR_CAPTURE);
      tester.walk(8'h01, 2);
      repeat (4) @(negedge clk_in);
      check_val(instr, 4'h3);
      check_val(pin_oe[6], 1'b0);
      // two data scans; capture reloads the last update value
      prev = SCAN_RESET;
      for (int i = 0; i < 2; i++) begin
         tester.walk(8'h01, 3);
         tester.shift(8, (i == 0) ? 8'ha5 : 8'h3c, d);
         tester.walk(8'h01, 2);
         repeat (4) @(negedge clk_in);
         check_val(d, prev);
         check_val(scan, (i == 0) ? 8'ha5 : 8'h3c);
         prev = scan;
      end
      // dropping the enable resets the controller and its registers
      tpe = 1'b0;
      repeat (4) @(negedge clk_in);
      check_val(instr, IR_RESET);
      check_val(scan, SCAN_RESET);
      // bypass code after reset: one-bit delay line, scan result untouched
      tpe = 1'b1;
      tester.walk(8'h02, 4);
      tester.shift(8, 8'h96, d);
      tester.walk(8'h01, 2);
      repeat (4) @(negedge clk_in);
      check_val(d, 8'h2c);
      check_val(scan, SCAN_RESET);
      check_val(instr, IR_BYPASS);
      $display("test 4 done");
      end_of_test();
   end
endmodule
